// ### acm_clkgen.sv
// acm_clkgen: link-domain divider for frame, bit and master clock outputs
// assumes: clk_i is 512fs in pll modes, 256/512/1024fs in external modes
`timescale 1ns/10ps
module acm_clkgen import acm_pkg::*;
(
   // link clock and main reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // configuration from main domain
   input wire logic [CFG_W-1:0] cfg_i,
   // clock outputs
   output logic frame_o,
   output logic bit_o,
   output logic mclk_o
);
   typedef struct packed {
      logic [9:0] cnt;
      logic frame;
      logic bclk;
      logic mclk;
   } acm_gen_s;

   acm_gen_s s_q;
   acm_gen_s s_d;
   logic [1:0] rst_q;
   logic lrst_n;
   logic [CFG_W-1:0] cfg;
   logic [1:0] ref_c;
   logic [3:0] frame_idx;
   logic [3:0] bit_idx;
   logic [3:0] mck_idx;

   // release of reset is retimed to the link clock
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         rst_q <= 2'h0;
      else
         rst_q <= {rst_q[0], 1'b1};
   end
   assign lrst_n = rst_q[1];

   acm_sync #(.W(CFG_W)) u_cfg_sync (
      .clk_i(clk_i),
      .rst_n_i(lrst_n),
      .d_i(cfg_i),
      .q_o(cfg)
   );

   always_comb
   begin
      s_d = s_q;
      ref_c = (cfg[CFG_REF_LSB+:2] == 2'h3) ? 2'h2 : cfg[CFG_REF_LSB+:2];
      frame_idx = FRAME_IDX_BASE + {2'h0, ref_c};
      bit_idx = frame_idx - (cfg[CFG_BCK] ? BCK64_SHIFT : BCK32_SHIFT);
      mck_idx = frame_idx - BCK32_SHIFT - {2'h0, cfg[CFG_RATIO_LSB+:2]};
      s_d.cnt = cfg[CFG_RUN] ? s_q.cnt + 10'h1 : 10'h0;
      // frame at 1fs, bit clock at 32fs or 64fs, low while held
      s_d.frame = cfg[CFG_DRIVE] && !cfg[CFG_HOLD] && s_q.cnt[frame_idx];
      s_d.bclk = cfg[CFG_DRIVE] && !cfg[CFG_HOLD] && s_q.cnt[bit_idx];
      s_d.mclk = cfg[CFG_MASTER_CLOCK_OUT] && s_q.cnt[mck_idx];
   end

   always_ff @(posedge clk_i or negedge lrst_n)
   begin
      if (!lrst_n)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   assign frame_o = s_q.frame;
   assign bit_o = s_q.bclk;
   assign mclk_o = s_q.mclk;

   a_mclk_low: assert property (@(posedge clk_i) disable iff (!lrst_n)
      !cfg[CFG_MASTER_CLOCK_OUT] |=> !s_q.mclk)
      else $error("master clock out toggles while disabled");
   a_held_low: assert property (@(posedge clk_i) disable iff (!lrst_n)
      (!cfg[CFG_DRIVE] || cfg[CFG_HOLD]) |=> (!s_q.frame && !s_q.bclk))
      else $error("frame or bit clock not low while held");
endmodule : acm_clkgen

// ### acm_far_end.sv
// acm_far_end: far-side serial port that masters frame and bit clocks
// assumes: clk_i is the link clock; released pins are pulled down outside
`timescale 1ns/10ps
module acm_far_end
(
   // link clock and enable
   input wire logic clk_i,
   input wire logic en_i,
   // clock pins
   output logic frame_o,
   output logic bit_o,
   output logic drive_o
);
   logic [5:0] cnt_q = 6'h00;
   // clocks stand still while not driving
   always_ff @(posedge clk_i)
   begin
      if (en_i)
      begin
         cnt_q <= cnt_q + 6'h01;
      end
   end
   // 32 bit clocks per frame, the slowest legal rate
   assign bit_o = cnt_q[0];
   // frame moves only with a falling bit edge, never a rising one
   assign frame_o = cnt_q[5];
   assign drive_o = en_i;
endmodule : acm_far_end

// ### acm_pkg.sv
// acm_pkg: register map, field positions and codes of the audio clock mode control
// assumes: 32-bit AXI4-Lite register bus, one aligned word per register
package acm_pkg;
   // register byte offsets
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   // control register fields
   localparam int CTRL_MASTER_BIT = 0;
   localparam int CTRL_PLL_BIT = 1;
   localparam int CTRL_MASTER_CLOCK_OUT_EN_BIT = 2;
   localparam int CTRL_RATIO_LSB = 4;
   localparam int CTRL_BCK_RATE_BIT = 6;
   localparam int CTRL_FS_LSB = 8;
   localparam int CTRL_PLLREF_LSB = 12;
   localparam int CTRL_LPWR_BIT = 16;
   localparam int CTRL_RPWR_BIT = 17;
   localparam logic [17:0] CTRL_WMASK = 18'h3F377;
   localparam logic [17:0] CTRL_RESET = 18'h00000;
   // status register fields
   localparam int STAT_MODE_LSB = 0;
   localparam int STAT_LOCK_BIT = 3;
   localparam int STAT_VALID_BIT = 4;
   localparam int STAT_HOLD_BIT = 5;
   localparam int STAT_DRIVE_BIT = 6;
   localparam int STAT_BCLK_BIT = 7;
   // bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // frame-clock rising edges before serial output is valid
   localparam logic [10:0] VALID_DELAY_EDGES = 11'h423;
   // link configuration word, main domain to link domain
   localparam int CFG_W = 9;
   localparam int CFG_DRIVE = 0;
   localparam int CFG_HOLD = 1;
   localparam int CFG_MASTER_CLOCK_OUT = 2;
   localparam int CFG_REF_LSB = 3;
   localparam int CFG_RATIO_LSB = 5;
   localparam int CFG_BCK = 7;
   localparam int CFG_RUN = 8;
   // reference ratio codes: 0 = 256fs, 1 = 512fs, 2/3 = 1024fs
   localparam logic [1:0] PLL_REF_CODE = 2'h1;
   localparam logic [3:0] FRAME_IDX_BASE = 4'h7;
   localparam logic [3:0] BCK32_SHIFT = 4'h5;
   localparam logic [3:0] BCK64_SHIFT = 4'h6;

   typedef enum logic [2:0] {
      ACM_EXT_SLAVE = 3'b000,
      ACM_EXT_MASTER = 3'b001,
      ACM_PLL_SLAVE = 3'b010,
      ACM_PLL_MASTER = 3'b011,
      ACM_PLL_SLAVE_FB = 3'b100
   } acm_mode_e;

   typedef enum logic [1:0] {
      ACM_OUT_OFF = 2'b00,
      ACM_OUT_WAIT = 2'b01,
      ACM_OUT_VALID = 2'b10
   } acm_out_e;
endpackage : acm_pkg

// ### acm_sync.sv
// acm_sync: two flip-flop level synchroniser, one stage pair per bit
// assumes: inputs are levels that stay long enough to be seen
`timescale 1ns/10ps
module acm_sync #(parameter int W = 1)
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // levels
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   genvar i;
   generate
      for (i = 0; i < W; i++)
      begin : g_bit
         logic [1:0] ff_q;
         always_ff @(posedge clk_i or negedge rst_n_i)
         begin
            if (!rst_n_i)
               ff_q <= 2'h0;
            else
               ff_q <= {ff_q[0], d_i[i]};
         end
         assign q_o[i] = ff_q[1];
      end
   endgenerate
endmodule : acm_sync

// ### acm_top.sv
// acm_top: clock mode selection, clock pin direction and output-valid delay
// assumes: AXI4-Lite master on MCLK_I, link clock on MASTER_CLOCK_IN_I, pins resolved outside
//
// Implementation choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/10ps
module acm_top import acm_pkg::*;
#(
   parameter logic [10:0] VALID_EDGES = VALID_DELAY_EDGES
)
(
   // clock and reset
   input wire logic MCLK_I,
   input wire logic RESET_N_I,
   // axi4-lite write
   input wire logic [7:0] S_AXI_AWADDR_I,
   input wire logic S_AXI_AWVALID_I,
   output logic S_AXI_AWREADY_O,
   input wire logic [31:0] S_AXI_WDATA_I,
   input wire logic [3:0] S_AXI_WSTRB_I,
   input wire logic S_AXI_WVALID_I,
   output logic S_AXI_WREADY_O,
   output logic [1:0] S_AXI_BRESP_O,
   output logic S_AXI_BVALID_O,
   input wire logic S_AXI_BREADY_I,
   // axi4-lite read
   input wire logic [7:0] S_AXI_ARADDR_I,
   input wire logic S_AXI_ARVALID_I,
   output logic S_AXI_ARREADY_O,
   output logic [31:0] S_AXI_RDATA_O,
   output logic [1:0] S_AXI_RRESP_O,
   output logic S_AXI_RVALID_O,
   input wire logic S_AXI_RREADY_I,
   // link clocks
   input wire logic MASTER_CLOCK_IN_I,
   output logic MASTER_CLOCK_OUT_O,
   input wire logic FRAME_CLOCK_I,
   output logic FRAME_CLOCK_O,
   output logic FRAME_CLOCK_OE_O,
   input wire logic SERIAL_BIT_CLOCK_I,
   output logic SERIAL_BIT_CLOCK_O,
   output logic SERIAL_BIT_CLOCK_OE_O,
   // pll and converter
   input wire logic PLL_LOCK_I,
   input wire logic AUDIO_DATA_I,
   output logic SERIAL_AUDIO_OUT_O
);
   typedef struct packed {
      logic aw_got;
      logic [7:0] aw_addr;
      logic w_got;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [17:0] ctrl;
      acm_mode_e mode;
      logic [CFG_W-1:0] cfg;
      logic pll_prev;
      logic hold;
      logic drive;
      acm_out_e out_st;
      logic [10:0] edge_cnt;
      logic frame_prev;
      logic sdo;
   } acm_top_s;

   acm_top_s s_q;
   acm_top_s s_d;
   logic aw_fire;
   logic w_fire;
   logic ar_fire;
   logic wr_go;
   logic [7:0] wa;
   logic [31:0] wd;
   logic [3:0] ws;
   logic [31:0] wide;
   logic [31:0] status;
   logic pll;
   logic ms;
   logic pwr;
   logic fb_ref;
   logic frame_src;
   logic rise;
   logic gen_frame;
   logic [3:0] sync_q;
   logic lock_s;

   // pins and the link-domain frame clock, two flops each
   acm_sync #(.W(4)) u_in_sync (
      .clk_i(MCLK_I),
      .rst_n_i(RESET_N_I),
      .d_i({PLL_LOCK_I, SERIAL_BIT_CLOCK_I, FRAME_CLOCK_I, gen_frame}),
      .q_o(sync_q)
   );
   assign lock_s = sync_q[3];

   acm_clkgen u_clkgen (
      .clk_i(MASTER_CLOCK_IN_I),
      .rst_n_i(RESET_N_I),
      .cfg_i(s_q.cfg),
      .frame_o(gen_frame),
      .bit_o(SERIAL_BIT_CLOCK_O),
      .mclk_o(MASTER_CLOCK_OUT_O)
   );
   assign FRAME_CLOCK_O = gen_frame;

   always_comb
   begin
      s_d = s_q;
      // bus handshakes
      aw_fire = S_AXI_AWVALID_I && S_AXI_AWREADY_O;
      w_fire = S_AXI_WVALID_I && S_AXI_WREADY_O;
      ar_fire = S_AXI_ARVALID_I && S_AXI_ARREADY_O;
      wa = aw_fire ? S_AXI_AWADDR_I : s_q.aw_addr;
      wd = w_fire ? S_AXI_WDATA_I : s_q.w_data;
      ws = w_fire ? S_AXI_WSTRB_I : s_q.w_strb;
      wr_go = (s_q.aw_got || aw_fire) && (s_q.w_got || w_fire);
      if (aw_fire)
      begin
         s_d.aw_got = 1'b1;
         s_d.aw_addr = S_AXI_AWADDR_I;
      end
      if (w_fire)
      begin
         s_d.w_got = 1'b1;
         s_d.w_data = S_AXI_WDATA_I;
         s_d.w_strb = S_AXI_WSTRB_I;
      end
      wide = {14'h0, s_q.ctrl};
      for (int b = 0; b < 4; b++)
      begin
         if (ws[b])
            wide[b*8+:8] = wd[b*8+:8];
      end
      if (s_q.bvalid && S_AXI_BREADY_I)
         s_d.bvalid = 1'b0;
      if (wr_go)
      begin
         s_d.aw_got = 1'b0;
         s_d.w_got = 1'b0;
         s_d.bvalid = 1'b1;
         s_d.bresp = RESP_OKAY;
         // status writes are ignored, other words refused
         if (wa[7:2] == ADDR_CTRL[7:2])
            s_d.ctrl = wide[17:0] & CTRL_WMASK;
         else if (wa[7:2] != ADDR_STATUS[7:2])
            s_d.bresp = RESP_SLVERR;
      end
      // status word
      status = 32'h0;
      status[STAT_MODE_LSB+:3] = s_q.mode;
      status[STAT_LOCK_BIT] = lock_s;
      status[STAT_VALID_BIT] = (s_q.out_st == ACM_OUT_VALID);
      status[STAT_HOLD_BIT] = s_q.hold;
      status[STAT_DRIVE_BIT] = s_q.drive;
      status[STAT_BCLK_BIT] = sync_q[2];
      if (s_q.rvalid && S_AXI_RREADY_I)
         s_d.rvalid = 1'b0;
      if (ar_fire)
      begin
         s_d.rvalid = 1'b1;
         s_d.rresp = RESP_OKAY;
         if (S_AXI_ARADDR_I[7:2] == ADDR_CTRL[7:2])
            s_d.rdata = {14'h0, s_q.ctrl};
         else if (S_AXI_ARADDR_I[7:2] == ADDR_STATUS[7:2])
            s_d.rdata = status;
         else
         begin
            s_d.rdata = 32'h0;
            s_d.rresp = RESP_SLVERR;
         end
      end
      // clock mode decode
      pll = s_q.ctrl[CTRL_PLL_BIT];
      ms = s_q.ctrl[CTRL_MASTER_BIT];
      fb_ref = (s_q.ctrl[CTRL_PLLREF_LSB+:4] == 4'h0) || (s_q.ctrl[CTRL_PLLREF_LSB+:4] == 4'h2) ||
               (s_q.ctrl[CTRL_PLLREF_LSB+:4] == 4'h3);
      unique case ({pll, ms})
         2'b11: s_d.mode = ACM_PLL_MASTER;
         2'b10: s_d.mode = fb_ref ? ACM_PLL_SLAVE_FB : ACM_PLL_SLAVE;
         2'b01: s_d.mode = ACM_EXT_MASTER;
         2'b00: s_d.mode = ACM_EXT_SLAVE;
      endcase
      // pins driven only once the master bit is set
      s_d.drive = ms;
      // hold clocks low from pll power-up until lock
      s_d.pll_prev = pll;
      if (!pll || !ms)
         s_d.hold = 1'b0;
      else if (!s_q.pll_prev)
         s_d.hold = 1'b1;
      else if (lock_s)
         s_d.hold = 1'b0;
      // link configuration, registered so the crossing sees clean levels
      s_d.cfg[CFG_DRIVE] = ms;
      s_d.cfg[CFG_HOLD] = s_d.hold;
      s_d.cfg[CFG_MASTER_CLOCK_OUT] = s_q.ctrl[CTRL_MASTER_CLOCK_OUT_EN_BIT] && pll;
      s_d.cfg[CFG_REF_LSB+:2] = pll ? PLL_REF_CODE : s_q.ctrl[CTRL_FS_LSB+:2];
      s_d.cfg[CFG_RATIO_LSB+:2] = s_q.ctrl[CTRL_RATIO_LSB+:2];
      s_d.cfg[CFG_BCK] = s_q.ctrl[CTRL_BCK_RATE_BIT];
      s_d.cfg[CFG_RUN] = ms || s_d.cfg[CFG_MASTER_CLOCK_OUT];
      // frame clock is counted from the pin in slave modes
      frame_src = s_q.drive ? sync_q[0] : sync_q[1];
      rise = frame_src && !s_q.frame_prev;
      s_d.frame_prev = frame_src;
      pwr = s_q.ctrl[CTRL_LPWR_BIT] || s_q.ctrl[CTRL_RPWR_BIT];
      unique case (s_q.out_st)
         ACM_OUT_OFF:
         begin
            s_d.edge_cnt = 11'h0;
            if (pwr)
               s_d.out_st = ACM_OUT_WAIT;
         end
         ACM_OUT_WAIT:
         begin
            if (!pwr)
               s_d.out_st = ACM_OUT_OFF;
            else if (rise)
            begin
               s_d.edge_cnt = s_q.edge_cnt + 11'h1;
               if (s_q.edge_cnt == VALID_EDGES - 11'h1)
                  s_d.out_st = ACM_OUT_VALID;
            end
         end
         ACM_OUT_VALID:
         begin
            if (!pwr)
               s_d.out_st = ACM_OUT_OFF;
         end
         default: s_d.out_st = ACM_OUT_OFF;
      endcase
      // data stays low until the converter path has settled
      s_d.sdo = (s_q.out_st == ACM_OUT_VALID) && AUDIO_DATA_I;
   end

   // power-down reset clears every control bit, slave is the default
   always_ff @(posedge MCLK_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
      begin
         s_q <= '0;
         s_q.ctrl <= CTRL_RESET;
      end
      else
         s_q <= s_d;
   end

   assign S_AXI_AWREADY_O = !s_q.aw_got && !s_q.bvalid;
   assign S_AXI_WREADY_O = !s_q.w_got && !s_q.bvalid;
   assign S_AXI_BVALID_O = s_q.bvalid;
   assign S_AXI_BRESP_O = s_q.bresp;
   assign S_AXI_ARREADY_O = !s_q.rvalid;
   assign S_AXI_RVALID_O = s_q.rvalid;
   assign S_AXI_RDATA_O = s_q.rdata;
   assign S_AXI_RRESP_O = s_q.rresp;
   assign FRAME_CLOCK_OE_O = s_q.drive;
   assign SERIAL_BIT_CLOCK_OE_O = s_q.drive;
   assign SERIAL_AUDIO_OUT_O = s_q.sdo;

   default clocking cb @(posedge MCLK_I);
   endclocking
   default disable iff (!RESET_N_I);

   sequence s_ctrl_write;
      wr_go && (wa[7:2] == ADDR_CTRL[7:2]) && (ws == 4'hF);
   endsequence
   sequence s_to_master;
      !s_q.ctrl[CTRL_MASTER_BIT] ##1 s_q.ctrl[CTRL_MASTER_BIT];
   endsequence
   sequence s_pll_up;
      !s_q.ctrl[CTRL_PLL_BIT] ##1 (s_q.ctrl[CTRL_PLL_BIT] && s_q.ctrl[CTRL_MASTER_BIT] && !lock_s);
   endsequence

   a_ctrl_apply: assert property (
      s_ctrl_write |=> s_q.ctrl == ($past(wd[17:0]) & CTRL_WMASK))
      else $error("control write not applied next cycle");
   a_master_entry: assert property (
      s_to_master |-> $past(wr_go))
      else $error("master bit set without a bus write");
   a_pll_master: assert property (
      (s_q.ctrl[CTRL_PLL_BIT] && s_q.ctrl[CTRL_MASTER_BIT]) |=> s_q.mode == ACM_PLL_MASTER)
      else $error("pll master mode not entered");
   a_ext_modes: assert property (
      !s_q.ctrl[CTRL_PLL_BIT] |=>
         s_q.mode == ($past(s_q.ctrl[CTRL_MASTER_BIT]) ? ACM_EXT_MASTER : ACM_EXT_SLAVE))
      else $error("external mode decode wrong");
   a_ext_ratio: assert property (
      !s_q.ctrl[CTRL_PLL_BIT] |=> s_q.cfg[CFG_REF_LSB+:2] == $past(s_q.ctrl[CTRL_FS_LSB+:2]))
      else $error("external ratio not from sample-rate bits");
   a_ext_no_mclk: assert property (
      !s_q.ctrl[CTRL_PLL_BIT] |=> !s_q.cfg[CFG_MASTER_CLOCK_OUT])
      else $error("master clock enabled without pll");
   a_pins_undriven: assert property (
      !s_q.ctrl[CTRL_MASTER_BIT] |=> (!FRAME_CLOCK_OE_O && !SERIAL_BIT_CLOCK_OE_O))
      else $error("clock pins driven in slave mode");
   a_hold_lock: assert property (
      s_pll_up |=> s_q.hold && s_q.cfg[CFG_HOLD])
      else $error("clocks not held low after pll power-up");
   a_valid_count: assert property (
      $rose(s_q.out_st == ACM_OUT_VALID) |-> ($past(s_q.edge_cnt) == VALID_EDGES - 11'h1) && $past(rise))
      else $error("output valid before the frame edge count");
   a_valid_off: assert property (
      !(s_q.ctrl[CTRL_LPWR_BIT] || s_q.ctrl[CTRL_RPWR_BIT]) |=> ##1 !SERIAL_AUDIO_OUT_O)
      else $error("serial output active with converters off");
   a_bresp_hold: assert property (
      (s_q.bvalid && !S_AXI_BREADY_I) |=> s_q.bvalid && $stable(s_q.bresp))
      else $error("write response dropped before ready");

   // once lock is seen the hold must let go, or frame and bit clocks never start
   sequence s_lock_seen;
      s_q.hold && lock_s && s_q.pll_prev;
   endsequence

   a_lock_release: assert property (
      s_lock_seen |=> !s_q.hold)
      else $error("clocks still held low after pll lock");
   a_mclk_gate: assert property (
      !s_q.ctrl[CTRL_MASTER_CLOCK_OUT_EN_BIT] |=> !s_q.cfg[CFG_MASTER_CLOCK_OUT])
      else $error("master clock enabled with its enable bit clear");
   a_pll_ratio: assert property (
      s_q.ctrl[CTRL_PLL_BIT] |=> s_q.cfg[CFG_RATIO_LSB+:2] == $past(s_q.ctrl[CTRL_RATIO_LSB+:2]))
      else $error("master clock ratio not taken from the ratio field");
   a_drive_master: assert property (
      s_q.ctrl[CTRL_MASTER_BIT] |=> s_q.cfg[CFG_DRIVE] && s_q.drive)
      else $error("master mode does not drive the clocks");
endmodule : acm_top

// ### testbench.sv
// testbench: bus, clock-mode and output-valid checks of acm_top
// assumes: clock pins pulled down when nobody drives; far side is acm_far_end
`timescale 1ns/10ps
module testbench import acm_pkg::*;
();
   localparam int LIMIT = 95000;
   // mid-run reset spans three link edges so the link domain clears as well
   localparam int RST_CYC = 40;
   localparam logic [15:0] MC [10] = '{16'h0000, 16'hF000, 16'h0001, 16'hF001, 16'h0003,
      16'h0002, 16'h2002, 16'h3002, 16'h4002, 16'hF002};
   localparam logic [2:0] MM [10] = '{3'h0, 3'h0, 3'h1, 3'h1, 3'h3, 3'h4, 3'h4, 3'h4, 3'h2, 3'h2};
   localparam logic [31:0] CC [6] = '{32'h0005, 32'h0175, 32'h0047, 32'h0047, 32'h0037, 32'h0023};
   localparam int CF [6] = '{2, 1, 0, 1, 1, 1};
   localparam int CB [6] = '{64, 64, 0, 64, 32, 32};
   localparam int CM [6] = '{0, 0, -1, 32, 256, 0};
   logic mclk = 1'b0;
   logic lclk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic lock = 1'b0, adat = 1'b0, far_en = 1'b0, fr_d = 1'b0;
   logic [31:0] seed = 32'h6F5D;
   logic awready, wready, bvalid, arready, rvalid, mco, fro, froe, bco, bcoe, sao;
   logic far_fr, far_bc, far_drv, fr_pin, bc_pin;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [65:0] ecur;
   logic [65:0] exp_r[$];
   logic [1:0] exp_b[$];
   int n_fail = 0;
   int n_tests = 0;
   int cyc = 0;
   int frise = 0;
   // a pin with no driver reads the pull-down level
   assign fr_pin = froe ? fro : (far_drv ? far_fr : 1'b0);
   assign bc_pin = bcoe ? bco : (far_drv ? far_bc : 1'b0);
   acm_top #(.VALID_EDGES(11'h004)) dut_u (.MCLK_I(mclk), .RESET_N_I(rst_n),
      .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready),
      .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(wstrb), .S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(wready),
      .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
      .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready),
      .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready),
      .MASTER_CLOCK_IN_I(lclk), .MASTER_CLOCK_OUT_O(mco), .FRAME_CLOCK_I(fr_pin), .FRAME_CLOCK_O(fro),
      .FRAME_CLOCK_OE_O(froe), .SERIAL_BIT_CLOCK_I(bc_pin), .SERIAL_BIT_CLOCK_O(bco),
      .SERIAL_BIT_CLOCK_OE_O(bcoe), .PLL_LOCK_I(lock), .AUDIO_DATA_I(adat), .SERIAL_AUDIO_OUT_O(sao));
   acm_far_end far_u (.clk_i(lclk), .en_i(far_en), .frame_o(far_fr), .bit_o(far_bc), .drive_o(far_drv));
   initial
   begin
      forever #2 mclk = ~mclk;
   end
   initial
   begin
      #7;
      forever #24 lclk = ~lclk;
   end
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs
   task automatic chk_word(input string n, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e)
      begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask : chk_word
   task automatic chk_count(input string n, input int e, input int g);
      n_tests++;
      if (g != e)
      begin
         n_fail++;
         $display("mismatch %s expected %0d seen %0d", n, e, g);
      end
   endtask : chk_count
   task automatic done(input string n);
      $display("test %s done", n);
   endtask : done
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : print_verdict
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
      logic ta, tw, ha, hw;
      exp_b.push_back(er);
      ta = 1'b0;
      tw = 1'b0;
      @(posedge mclk);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(ta && tw))
      begin
         @(negedge mclk);
         ha = awvalid & (awready === 1'b1);
         hw = wvalid & (wready === 1'b1);
         @(posedge mclk);
         awvalid <= awvalid & ~ha;
         wvalid <= wvalid & ~hw;
         ta = ta | ha;
         tw = tw | hw;
      end
      ha = 1'b0;
      while (!ha)
      begin
         @(negedge mclk);
         ha = (bvalid === 1'b1);
         @(posedge mclk);
      end
      bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, input logic [1:0] er);
      logic h;
      exp_r.push_back({er, m, e});
      @(posedge mclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      h = 1'b0;
      while (!h)
      begin
         @(negedge mclk);
         h = (arready === 1'b1);
         @(posedge mclk);
      end
      arvalid <= 1'b0;
      h = 1'b0;
      while (!h)
      begin
         @(negedge mclk);
         h = (rvalid === 1'b1);
         @(posedge mclk);
      end
      rready <= 1'b0;
   endtask : rd
   task automatic measure(input int n, output int f, output int b, output int m);
      logic pf, pb, pm;
      f = 0;
      b = 0;
      m = 0;
      @(negedge lclk);
      {pf, pb, pm} = {fro, bco, mco};
      repeat (n)
      begin
         @(negedge lclk);
         f += (fro === 1'b1 && pf === 1'b0);
         b += (bco === 1'b1 && pb === 1'b0);
         m += (mco === 1'b1 && pm === 1'b0);
         {pf, pb, pm} = {fro, bco, mco};
      end
   endtask : measure
   // results are compared in the order they were requested
   always @(negedge mclk)
   begin
      if (bvalid === 1'b1 && bready === 1'b1)
         chk_word("bresp", {30'h0, exp_b.pop_front()}, {30'h0, bresp});
      if (rvalid === 1'b1 && rready === 1'b1)
      begin
         ecur = exp_r.pop_front();
         chk_word("rdata", ecur[31:0], rdata & ecur[63:32]);
         chk_word("rresp", {30'h0, ecur[65:64]}, {30'h0, rresp});
      end
      fr_d <= fr_pin;
      if (fr_pin === 1'b1 && fr_d === 1'b0)
         frise <= frise + 1;
   end
   always @(posedge mclk)
   begin
      adat <= ^xs();
      cyc <= cyc + 1;
      if (cyc == LIMIT)
      begin
         n_fail++;
         print_verdict();
      end
   end
   initial
   begin : main
      logic [31:0] r;
      int f, b, m, base;
      logic pd;
      repeat (6) @(posedge mclk);
      rst_n <= 1'b1;
      rd(ADDR_CTRL, 32'h0, 32'hFFFFFFFF, RESP_OKAY);
      rd(ADDR_STATUS, 32'h0, 32'h47, RESP_OKAY);
      chk_word("fr_oe", 32'h0, {31'h0, froe});
      done("reset");
      r = xs();
      wr(ADDR_CTRL, 32'hFFFFFFFF, r[3:0], RESP_OKAY);
      rd(ADDR_CTRL, {14'h0, CTRL_WMASK} & {{8{r[3]}}, {8{r[2]}}, {8{r[1]}}, {8{r[0]}}},
         32'hFFFFFFFF, RESP_OKAY);
      wr(ADDR_CTRL, 32'h0, 4'hF, RESP_OKAY);
      wr(ADDR_STATUS, 32'hFFFFFFFF, 4'hF, RESP_OKAY);
      wr(8'h10, 32'hFFFFFFFF, 4'hF, RESP_SLVERR);
      rd(8'h10, 32'h0, 32'hFFFFFFFF, RESP_SLVERR);
      rd(ADDR_CTRL, 32'h0, 32'hFFFFFFFF, RESP_OKAY);
      done("bus");
      for (int i = 0; i < 10; i++)
      begin
         wr(ADDR_CTRL, {16'h0, MC[i]}, 4'hF, RESP_OKAY);
         rd(ADDR_STATUS, {25'h0, MC[i][0], 3'h0, MM[i]}, 32'h47, RESP_OKAY);
         chk_word("bit_oe", {31'h0, MC[i][0]}, {31'h0, bcoe});
         chk_word("fr_oe", {31'h0, MC[i][0]}, {31'h0, froe});
      end
      done("modes");
      for (int i = 0; i < 6; i++)
      begin
         lock <= (i > 2);
         wr(ADDR_CTRL, CC[i], 4'hF, RESP_OKAY);
         repeat ((i == 3) ? 600 : 300) @(negedge lclk);
         measure(512, f, b, m);
         chk_count("frame_rises", CF[i], f);
         chk_count("bit_rises", CB[i], b);
         if (CM[i] >= 0)
            chk_count("mclk_rises", CM[i], m);
         rd(ADDR_STATUS, {26'h0, i == 2, 1'b0, i > 2, 1'b0, i > 1, 1'b1}, 32'h3F, RESP_OKAY);
      end
      done("clocks");
      wr(ADDR_CTRL, 32'h10000, 4'hF, RESP_OKAY);
      base = frise;
      far_en <= 1'b1;
      wait (frise == base + 3);
      repeat (8)
      begin
         @(negedge mclk);
         chk_word("audio_out", 32'h0, {31'h0, sao});
      end
      rd(ADDR_STATUS, 32'h0, 32'h10, RESP_OKAY);
      wait (frise == base + 4);
      repeat (8) @(negedge mclk);
      rd(ADDR_STATUS, 32'h10, 32'h10, RESP_OKAY);
      @(negedge mclk);
      pd = adat;
      repeat (8)
      begin
         @(negedge mclk);
         chk_word("audio_out", {31'h0, pd}, {31'h0, sao});
         pd = adat;
      end
      done("valid_delay");
      far_en <= 1'b0;
      wr(ADDR_CTRL, 32'h0001, 4'hF, RESP_OKAY);
      @(posedge mclk);
      rst_n <= 1'b0;
      repeat (RST_CYC) @(posedge mclk);
      chk_word("fr_oe", 32'h0, {31'h0, froe});
      chk_word("audio_out", 32'h0, {31'h0, sao});
      rst_n <= 1'b1;
      rd(ADDR_CTRL, 32'h0, 32'hFFFFFFFF, RESP_OKAY);
      rd(ADDR_STATUS, 32'h0, 32'h57, RESP_OKAY);
      done("second_reset");
      print_verdict();
   end
endmodule : testbench
